/* p0pc_port0_pin_config.sv */
// Port-0 pin configuration core with APB register access
// Operation
// - Polarity bit 0 high-active, 1 low-active
// - Threshold bit selects TTL, reset gives CMOS
// - High-drive bit picks strong sink where present
// - Drain-only: data one floats, zero pulls low
// - Push-pull drives pin high and low
// - Pull-up bit connects pull-up resistor
// - Drive-enable bit switches output driver
// - Crystal on forces clock pins' drivers off
// - Crystal on ignores clock pin settings
// - Serial-function bit hands enable to serial logic
// - Clock-out bit drives selected clock out
// - Three dedicated edge interrupts, polarity picks edge
// - Output pin data write raises interrupt
// - Polarity change may give spurious interrupt
// - Output without timer drive feeds data
// - First timer pin outputs fixed tick pulse
// - Second timer pin outputs programmable tick
// - Pin controls apply in timer use too
// - Interrupt-enable bit gates pin edge interrupts
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module p0pc_port0_pin_config #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [8:0] pad_in,
  output logic [8:0] pad_out,
  output logic [8:0] pad_oe_n,
  output logic [8:0] pad_pull_up,
  output logic [8:0] pad_ttl,
  output logic [8:0] pad_high_sink,
  input wire logic [3:0] clk_src,
  input wire logic fixed_tick,
  input wire logic prog_tick,
  input wire logic [1:0] serial_oe,
  input wire logic [1:0] serial_do,
  output logic [1:0] serial_rx,
  output logic [2:0] ext_irq_event,
  output logic [3:0] gpio_irq_event,
  output logic [1:0] timer_in
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [8:0] pad_sync;
  logic [3:0] clk_src_sync;

  p0pc_sync #(.WIDTH(9)) u_pad_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_async(pad_in),
    .out_sync(pad_sync)
  );

  p0pc_sync #(.WIDTH(4)) u_clk_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_async(clk_src),
    .out_sync(clk_src_sync)
  );

  assign serial_rx = pad_sync[8:7];

  // ----------------------------------------------------------------
  // Register file and APB slave
  // ----------------------------------------------------------------
  logic [7:0] cfg_reg [0:6];
  logic [7:0] cfg_next [0:6];
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [7:0] clkio_reg;
  logic [7:0] clkio_next;
  logic [7:0] serial_reg;
  logic [7:0] serial_next;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;
  logic [9:0] idx_c;
  logic hit_c;
  logic wr_c;
  logic [7:0] rd_c;
  logic [7:0] wb_c;
  logic [7:0] pin_state_c;
  logic crystal_osc_on;

  assign crystal_osc_on = clkio_reg[p0pc_pkg::CLKIO_XOSC];

  function automatic logic [7:0] cfg_mask(input int unsigned pin);
    case (pin)
      0: cfg_mask = p0pc_pkg::MASK_CLOCK_IN;
      1: cfg_mask = p0pc_pkg::MASK_CLOCK_OUT;
      2, 3, 4: cfg_mask = p0pc_pkg::MASK_EXT_IRQ;
      default: cfg_mask = p0pc_pkg::MASK_TIMER;
    endcase
  endfunction

  always_comb
  begin
    idx_c = paddr[11:2];
    hit_c = 1'b0;
    rd_c = 8'h00;
    if (paddr[1:0] == 2'b00 && (paddr >> 12) == '0)
    begin
      if (idx_c == p0pc_pkg::IDX_PORT_DATA)
      begin
        hit_c = 1'b1;
        rd_c = pin_state_c;
      end
      else if (idx_c >= p0pc_pkg::IDX_CLOCK_IN && idx_c <= p0pc_pkg::IDX_TIMER1)
      begin
        hit_c = 1'b1;
        rd_c = cfg_reg[3'(idx_c - p0pc_pkg::IDX_CLOCK_IN)];
      end
      else if (idx_c == p0pc_pkg::IDX_CLOCK_IO)
      begin
        hit_c = 1'b1;
        rd_c = clkio_reg;
      end
      else if (idx_c == p0pc_pkg::IDX_SERIAL)
      begin
        hit_c = 1'b1;
        rd_c = serial_reg;
      end
    end
    // Write lands only at the completing edge of the access phase
    wr_c = psel & penable & pready & pwrite & hit_c & pstrb[0];
    wb_c = pwdata[7:0];
    for (int i = 0; i < 7; i++)
      cfg_next[i] = p0pc_pkg::apply_write(cfg_reg[i], wb_c, cfg_mask(i),
        wr_c && idx_c == p0pc_pkg::IDX_CLOCK_IN + 10'(i));
    data_next = p0pc_pkg::apply_write(data_reg, wb_c, p0pc_pkg::MASK_PORT_DATA,
      wr_c && idx_c == p0pc_pkg::IDX_PORT_DATA);
    clkio_next = p0pc_pkg::apply_write(clkio_reg, wb_c, p0pc_pkg::MASK_CLOCK_IO,
      wr_c && idx_c == p0pc_pkg::IDX_CLOCK_IO);
    serial_next = p0pc_pkg::apply_write(serial_reg, wb_c, p0pc_pkg::MASK_SERIAL,
      wr_c && idx_c == p0pc_pkg::IDX_SERIAL);
    // One wait state so every bus output can come from a flop
    pready_next = psel & penable & ~pready;
    pslverr_next = psel & penable & ~pready & ~hit_c;
    prdata_next = (psel & penable & ~pready & ~pwrite) ? {24'h000000, rd_c} : 32'h00000000;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 7; i++)
        cfg_reg[i] <= p0pc_pkg::RST_CFG;
      data_reg <= p0pc_pkg::RST_CFG;
      clkio_reg <= p0pc_pkg::RST_CFG;
      serial_reg <= p0pc_pkg::RST_CFG;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 7; i++)
        cfg_reg[i] <= cfg_next[i];
      data_reg <= data_next;
      clkio_reg <= clkio_next;
      serial_reg <= serial_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------
  logic [7:0] eff_c [0:6];
  logic [8:0] drive_en_c;
  logic [8:0] drive_val_c;
  logic [8:0] od_c;
  logic [8:0] pu_c;
  logic [8:0] ttl_c;
  logic [8:0] hs_c;
  logic [6:0] sense_c;
  logic [6:0] act_c;
  logic clk_sel_c;

  always_comb
  begin
    clk_sel_c = clk_src_sync[clkio_reg[1:0]];
    for (int i = 0; i < 7; i++)
    begin
      // Crystal mode hides the clock pins' settings entirely
      eff_c[i] = (crystal_osc_on && i < 2) ? 8'h00 : cfg_reg[i];
      drive_en_c[i] = eff_c[i][p0pc_pkg::BIT_OE];
      drive_val_c[i] = data_reg[i];
      od_c[i] = eff_c[i][p0pc_pkg::BIT_OD];
      pu_c[i] = eff_c[i][p0pc_pkg::BIT_PU];
      ttl_c[i] = eff_c[i][p0pc_pkg::BIT_TTL];
      hs_c[i] = eff_c[i][p0pc_pkg::BIT_HS];
    end
    if (eff_c[1][p0pc_pkg::BIT_ALT])
    begin
      drive_en_c[1] = 1'b1;
      drive_val_c[1] = clk_sel_c;
    end
    // Ticks pass through ungated by any interrupt enable
    if (eff_c[5][p0pc_pkg::BIT_ALT] & eff_c[5][p0pc_pkg::BIT_OE])
      drive_val_c[5] = fixed_tick;
    if (eff_c[6][p0pc_pkg::BIT_ALT] & eff_c[6][p0pc_pkg::BIT_OE])
      drive_val_c[6] = prog_tick;
    for (int s = 0; s < 2; s++)
    begin
      if (serial_reg[s])
      begin
        drive_en_c[7 + s] = serial_oe[s];
        drive_val_c[7 + s] = serial_do[s];
      end
      else
      begin
        drive_en_c[7 + s] = serial_reg[p0pc_pkg::SER_OE_LSB + s];
        drive_val_c[7 + s] = serial_reg[p0pc_pkg::SER_DATA_LSB + s];
      end
      od_c[7 + s] = 1'b0;
      pu_c[7 + s] = 1'b0;
      ttl_c[7 + s] = 1'b1;
      hs_c[7 + s] = 1'b0;
    end
    for (int i = 0; i < 7; i++)
    begin
      // A driven pin senses its own driven level (data, selected clock or tick)
      sense_c[i] = drive_en_c[i] ? drive_val_c[i] : pad_sync[i];
      // Toggling polarity flips this level, so a spurious edge occurs when it flips from 0 to 1
      act_c[i] = sense_c[i] ^ eff_c[i][p0pc_pkg::BIT_POL];
      pin_state_c[i] = (crystal_osc_on && i < 2) ? 1'b0 : sense_c[i];
    end
    pin_state_c[7] = 1'b0;
  end

  for (genvar g = 0; g < 9; g++)
  begin : g_pin
    p0pc_pin_cell u_cell (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .drive_en(drive_en_c[g]),
      .drive_val(drive_val_c[g]),
      .open_drain(od_c[g]),
      .pull_up(pu_c[g]),
      .ttl(ttl_c[g]),
      .high_sink(hs_c[g]),
      .pad_out(pad_out[g]),
      .pad_oe_n(pad_oe_n[g]),
      .pad_pull_up(pad_pull_up[g]),
      .pad_ttl(pad_ttl[g]),
      .pad_high_sink(pad_high_sink[g])
    );
  end

  // ----------------------------------------------------------------
  // Edge events and timer inputs
  // ----------------------------------------------------------------
  logic [6:0] act_prev_reg;
  logic [6:0] act_prev_next;
  logic [6:0] edge_c;
  logic [2:0] ext_irq_next;
  logic [3:0] gpio_irq_next;
  logic [1:0] timer_in_next;

  always_comb
  begin
    act_prev_next = act_c;
    edge_c = act_c & ~act_prev_reg;
    ext_irq_next = edge_c[4:2];
    gpio_irq_next = {edge_c[6] & eff_c[6][p0pc_pkg::BIT_IE],
                     edge_c[5] & eff_c[5][p0pc_pkg::BIT_IE],
                     edge_c[1] & eff_c[1][p0pc_pkg::BIT_IE],
                     edge_c[0] & eff_c[0][p0pc_pkg::BIT_IE]};
    for (int t = 0; t < 2; t++)
      timer_in_next[t] = (eff_c[5 + t][p0pc_pkg::BIT_OE] & ~eff_c[5 + t][p0pc_pkg::BIT_ALT])
        ? data_reg[5 + t] : pad_sync[5 + t];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_prev_reg <= 7'h00;
      ext_irq_event <= 3'h0;
      gpio_irq_event <= 4'h0;
      timer_in <= 2'h0;
    end
    else
    begin
      act_prev_reg <= act_prev_next;
      ext_irq_event <= ext_irq_next;
      gpio_irq_event <= gpio_irq_next;
      timer_in <= timer_in_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_EXT_RISE: assert property (
    ($rose(sense_c[2]) && $stable(eff_c[2][p0pc_pkg::BIT_POL]) && !eff_c[2][p0pc_pkg::BIT_POL])
    |=> ext_irq_event[0])
    else $error("rising edge on first dedicated pin gave no event");
  AST_EXT_FALL: assert property (
    ($fell(sense_c[3]) && $stable(eff_c[3][p0pc_pkg::BIT_POL]) && eff_c[3][p0pc_pkg::BIT_POL])
    |=> ext_irq_event[1])
    else $error("falling edge with low polarity gave no event");
  AST_OD_FLOAT: assert property (
    (drive_en_c[0] && od_c[0] && drive_val_c[0]) |=> pad_oe_n[0])
    else $error("drain-only pin driven while data is one");
  AST_PUSH_PULL: assert property (
    (drive_en_c[6] && !od_c[6]) |=> (!pad_oe_n[6] && pad_out[6] == $past(drive_val_c[6])))
    else $error("push-pull pin not following data");
  AST_XOSC_OFF: assert property (
    crystal_osc_on |=> (pad_oe_n[0] && pad_oe_n[1] && !pad_pull_up[0] && !pad_pull_up[1]))
    else $error("clock pins active while crystal enabled");
  AST_SERIAL_OE: assert property (
    serial_reg[0] |=> (pad_oe_n[7] == !$past(serial_oe[0])))
    else $error("serial pin enable not under serial control");
  AST_CLK_OUT: assert property (
    (cfg_reg[1][p0pc_pkg::BIT_ALT] && !crystal_osc_on && !cfg_reg[1][p0pc_pkg::BIT_OD])
    |=> (!pad_oe_n[1] && pad_out[1] == $past(clk_sel_c)))
    else $error("selected clock not on clock-out pin");
  AST_TIMER_FEED: assert property (
    (cfg_reg[5][p0pc_pkg::BIT_OE] && !cfg_reg[5][p0pc_pkg::BIT_ALT])
    |=> (timer_in[0] == $past(data_reg[5])))
    else $error("timer input not fed from port data");
  AST_TICK_OUT: assert property (
    (cfg_reg[5][p0pc_pkg::BIT_OE] && cfg_reg[5][p0pc_pkg::BIT_ALT]
     && !cfg_reg[5][p0pc_pkg::BIT_OD] && fixed_tick) |=> pad_out[5])
    else $error("fixed tick not on first timer pin");
  AST_CFG_PASS: assert property (
    1'b1 |=> (pad_ttl[5] == $past(cfg_reg[5][p0pc_pkg::BIT_TTL])
              && pad_pull_up[6] == $past(cfg_reg[6][p0pc_pkg::BIT_PU])))
    else $error("timer pin controls not applied");
  AST_GPIO_IE: assert property (
    !cfg_reg[0][p0pc_pkg::BIT_IE] |=> !gpio_irq_event[0])
    else $error("pin interrupt with enable clear");
  AST_RSVD_ZERO: assert property (
    ((cfg_reg[2] & ~p0pc_pkg::MASK_EXT_IRQ) == 8'h00)
    && ((cfg_reg[5] & ~p0pc_pkg::MASK_TIMER) == 8'h00))
    else $error("reserved bit holds a one");
  COV_EXT_IRQ: cover property (ext_irq_event[0] ##1 !ext_irq_event[0]);
  COV_CLK_OUT: cover property (cfg_reg[1][p0pc_pkg::BIT_ALT] && !pad_oe_n[1]);
  COV_TICK: cover property (fixed_tick && cfg_reg[5][p0pc_pkg::BIT_ALT] ##1 pad_out[5]);
  COV_SLVERR: cover property (pready && pslverr);

endmodule // p0pc_port0_pin_config

/* p0pc_pkg.sv */
// Constants shared by the port-0 pin configuration block
package p0pc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_PORT_DATA = 10'h000;
  localparam logic [9:0] IDX_CLOCK_IN = 10'h005;
  localparam logic [9:0] IDX_CLOCK_OUT = 10'h006;
  localparam logic [9:0] IDX_EXT_IRQ0 = 10'h007;
  localparam logic [9:0] IDX_EXT_IRQ1 = 10'h008;
  localparam logic [9:0] IDX_EXT_IRQ2 = 10'h009;
  localparam logic [9:0] IDX_TIMER0 = 10'h00a;
  localparam logic [9:0] IDX_TIMER1 = 10'h00b;
  localparam logic [9:0] IDX_CLOCK_IO = 10'h020;
  localparam logic [9:0] IDX_SERIAL = 10'h021;

  // ----------------------------------------------------------------
  // Writable-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_CLOCK_IN = 8'h7f;
  localparam logic [7:0] MASK_CLOCK_OUT = 8'hff;
  localparam logic [7:0] MASK_EXT_IRQ = 8'h37;
  localparam logic [7:0] MASK_TIMER = 8'hf7;
  localparam logic [7:0] MASK_PORT_DATA = 8'h7f;
  localparam logic [7:0] MASK_CLOCK_IO = 8'h07;
  localparam logic [7:0] MASK_SERIAL = 8'h3f;
  localparam logic [7:0] RST_CFG = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_OE = 0;
  localparam int unsigned BIT_PU = 1;
  localparam int unsigned BIT_OD = 2;
  localparam int unsigned BIT_HS = 3;
  localparam int unsigned BIT_TTL = 4;
  localparam int unsigned BIT_POL = 5;
  localparam int unsigned BIT_IE = 6;
  localparam int unsigned BIT_ALT = 7;
  localparam int unsigned CLKIO_XOSC = 2;
  localparam int unsigned SER_OE_LSB = 2;
  localparam int unsigned SER_DATA_LSB = 4;

  // Masked register update; reserved bits always stay zero
  function automatic logic [7:0] apply_write(input logic [7:0] old_val,
                                             input logic [7:0] wdata,
                                             input logic [7:0] mask,
                                             input logic sel);
    apply_write = sel ? (wdata & mask) : old_val;
  endfunction

endpackage

/* p0pc_sync.sv */
// Two-stage synchroniser for pin and foreign-clock inputs
`timescale 1ns/1ps
module p0pc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_async,
  output logic [WIDTH-1:0] out_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] out_next;

  always_comb
  begin
    meta_next = in_async;
    out_next = meta_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      out_sync <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      out_sync <= out_next;
    end
  end

endmodule // p0pc_sync

/* p0pc_pin_cell.sv */
// Registered pad driver for one pin
`timescale 1ns/1ps
module p0pc_pin_cell (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic drive_en,
  input wire logic drive_val,
  input wire logic open_drain,
  input wire logic pull_up,
  input wire logic ttl,
  input wire logic high_sink,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_pull_up,
  output logic pad_ttl,
  output logic pad_high_sink
);

  logic out_next;
  logic oe_n_next;

  always_comb
  begin
    // Drain-only floats a one and pulls a zero low
    out_next = open_drain ? 1'b0 : drive_val;
    oe_n_next = ~(drive_en & ~(open_drain & drive_val));
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
      pad_pull_up <= 1'b0;
      pad_ttl <= 1'b0;
      pad_high_sink <= 1'b0;
    end
    else
    begin
      pad_out <= out_next;
      pad_oe_n <= oe_n_next;
      pad_pull_up <= pull_up;
      pad_ttl <= ttl;
      pad_high_sink <= high_sink;
    end
  end

endmodule // p0pc_pin_cell

/* p0pc_board.sv */
// Board-side model of the port-0 and serial pins
`timescale 1ns/1ps
module p0pc_board (
  input wire logic sys_clk,
  input wire logic [8:0] pad_out,
  input wire logic [8:0] pad_oe_n,
  input wire logic [8:0] pad_pull_up,
  input wire logic [8:0] ext_en,
  input wire logic [8:0] ext_val,
  output logic [8:0] pad_in
);
  // ------------------------------------------------------------
  // Pin level resolution
  // ------------------------------------------------------------
  // Undriven pins without pull-up toggle so a stale level never passes for a real one
  logic [8:0] float_reg = 9'h0aa;
  logic [8:0] float_next;

  always_comb
  begin
    float_next = ~float_reg;
    for (int i = 0; i < 9; i++)
    begin
      if (!pad_oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pull_up[i])
        pad_in[i] = 1'b1;
      else
        pad_in[i] = float_reg[i];
    end
  end

  always_ff @(posedge sys_clk)
    float_reg <= float_next;
endmodule // p0pc_board

/* p0pc_port0_pin_config_tb.sv */
// Self-checking bench for the port-0 pin configuration block
`timescale 1ns/1ps
module p0pc_port0_pin_config_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [8:0] pad_in, pad_out, pad_oe_n, pad_pull_up, pad_ttl, pad_high_sink;
  logic [8:0] ext_en = 9'h078;
  logic [8:0] ext_val = 9'h000;
  logic [3:0] clk_src = 4'h0;
  logic fixed_tick = 1'b0;
  logic prog_tick = 1'b0;
  logic [1:0] serial_oe = 2'b00;
  logic [1:0] serial_do = 2'b01;
  logic [1:0] serial_rx, timer_in;
  logic [2:0] ext_irq_event;
  logic [3:0] gpio_irq_event;
  logic [6:0] ev_all;
  logic [7:0] r, d;
  logic e;
  int fail_count = 0;
  int tests_run = 0;
  int ev_cnt[7];
  int base, n, seed;

  p0pc_port0_pin_config dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pull_up(pad_pull_up), .pad_ttl(pad_ttl), .pad_high_sink(pad_high_sink),
    .clk_src(clk_src), .fixed_tick(fixed_tick), .prog_tick(prog_tick),
    .serial_oe(serial_oe), .serial_do(serial_do), .serial_rx(serial_rx),
    .ext_irq_event(ext_irq_event), .gpio_irq_event(gpio_irq_event),
    .timer_in(timer_in));

  p0pc_board board (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pull_up(pad_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Event counting and helpers
  // ------------------------------------------------------------
  assign ev_all = {gpio_irq_event, ext_irq_event};

  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 7; i++)
      if (ev_all[i] === 1'b1)
        ev_cnt[i]++;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until pready is sampled high; no fixed latency assumed
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic er);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      fail_count++;
      $display("wrong value apb_wait expected 1 seen %b", pready);
      test_done();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    logic [7:0] rd;
    logic er;
    apb(1'b1, idx, wd, rd, er);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    logic er;
    apb(1'b0, idx, 8'h00, rd, er);
    chk("reg_read", {1'b0, exp}, {1'b0, rd});
  endtask

  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic edge_ev(input int pin, input int ev, input logic lvl, input int exp);
    settle();
    base = ev_cnt[ev];
    ext_val[pin] <= lvl;
    settle();
    chk("irq_count", 9'(exp), 9'(ev_cnt[ev] - base));
  endtask

  function automatic logic [7:0] wmask(input logic [9:0] idx);
    case (idx)
      10'h005: wmask = p0pc_pkg::MASK_CLOCK_IN;
      10'h006: wmask = p0pc_pkg::MASK_CLOCK_OUT;
      10'h00a, 10'h00b: wmask = p0pc_pkg::MASK_TIMER;
      default: wmask = p0pc_pkg::MASK_EXT_IRQ;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 83893;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("oe_n_reset", 9'h1ff, pad_oe_n);
    chk("ttl_reset", 9'h000, pad_ttl);
    for (int i = 5; i < 12; i++)
      rdchk(10'(i), 8'h00);
    for (int k = 0; k < 14; k++)
    begin
      d = 8'($random(seed));
      wr(10'(5 + k % 7), d);
      rdchk(10'(5 + k % 7), d & wmask(10'(5 + k % 7)));
      wr(10'(5 + k % 7), 8'h00);
    end
    apb(1'b0, 10'h010, 8'h00, r, e);
    chk("unmapped_err", 9'h1, {8'h0, e});
    d = 8'($random(seed));
    wr(10'h000, {1'b0, d[6:0]});
    wr(10'h007, 8'h13);
    settle();
    chk("oe_n_pin2", 9'h0, 9'(pad_oe_n[2]));
    chk("out_pin2", 9'(d[2]), 9'(pad_out[2]));
    chk("pull_pin2", 9'h1, 9'(pad_pull_up[2]));
    chk("ttl_pin2", 9'h1, 9'(pad_ttl[2]));
    wr(10'h007, 8'h05);
    wr(10'h000, 8'h04);
    settle();
    chk("od_float", 9'h1, 9'(pad_oe_n[2]));
    wr(10'h000, 8'h00);
    settle();
    chk("od_low", 9'h0, 9'({pad_oe_n[2], pad_out[2]}));
    wr(10'h007, 8'h09);
    wr(10'h005, 8'h08);
    settle();
    chk("sink", 9'h1, 9'(pad_high_sink[0] + 2 * pad_high_sink[2]));
    base = ev_cnt[0];
    wr(10'h000, 8'h04);
    settle();
    chk("driven_irq", 9'h1, 9'(ev_cnt[0] - base));
    wr(10'h005, 8'h03);
    wr(10'h000, 8'h05);
    wr(10'h020, 8'h04);
    settle();
    chk("xtal_oe_n", 9'h3, 9'(pad_oe_n[1:0]));
    chk("xtal_pull", 9'h0, 9'(pad_pull_up[0]));
    apb(1'b0, 10'h000, 8'h00, r, e);
    chk("xtal_read", 9'h0, 9'(r[1:0]));
    wr(10'h020, 8'h00);
    settle();
    chk("gpio_oe_n", 9'h0, 9'(pad_oe_n[0]));
    wr(10'h006, 8'h80);
    for (int s = 0; s < 4; s++)
    begin
      r = 8'($random(seed));
      clk_src <= r[3:0];
      wr(10'h020, 8'(s));
      settle();
      chk("clk_out", 9'(r[s]), {pad_oe_n[1], 7'h0, pad_out[1]});
    end
    wr(10'h006, 8'h00);
    settle();
    chk("clk_off", 9'h1, 9'(pad_oe_n[1]));
    for (int p = 0; p < 2; p++)
    begin
      wr(10'h008, p ? 8'h20 : 8'h00);
      edge_ev(3, 1, 1'b1, 1 - p);
      edge_ev(3, 1, 1'b0, p);
    end
    for (int p = 0; p < 3; p++)
    begin
      wr(10'h00a, (p == 2) ? 8'h00 : ((p == 1) ? 8'h60 : 8'h40));
      edge_ev(5, 5, 1'b1, (p == 0) ? 1 : 0);
      edge_ev(5, 5, 1'b0, (p == 1) ? 1 : 0);
    end
    r = 8'($random(seed));
    ext_val[5] <= r[0];
    settle();
    chk("timer_in_pad", 9'(r[0]), 9'(timer_in[0]));
    wr(10'h00a, 8'h01);
    wr(10'h00b, 8'h01);
    for (int b = 0; b < 2; b++)
    begin
      wr(10'h000, b ? 8'h20 : 8'h40);
      settle();
      chk("timer_in_data", 9'(b ? 2'b01 : 2'b10), 9'(timer_in));
    end
    for (int j = 0; j < 2; j++)
    begin
      wr(10'(10 + j), 8'h83);
      settle();
      chk("timer_pull", 9'h1, 9'(pad_pull_up[5 + j]));
      n = 0;
      fixed_tick <= (j == 0);
      prog_tick <= (j == 1);
      @(posedge sys_clk);
      fixed_tick <= 1'b0;
      prog_tick <= 1'b0;
      repeat (6)
      begin
        @(posedge sys_clk);
        n += (pad_out[5 + j] === 1'b1);
      end
      chk("tick_pulse", 9'h1, 9'(n));
    end
    serial_oe <= 2'b01;
    wr(10'h021, 8'h01);
    settle();
    chk("serial_oe_on", 9'h0, 9'(pad_oe_n[7]));
    serial_oe <= 2'b00;
    settle();
    chk("serial_oe_off", 9'h1, 9'(pad_oe_n[7]));
    wr(10'h021, 8'h04);
    settle();
    chk("serial_gpio", 9'h0, 9'(pad_oe_n[7]));
    r = 8'($random(seed));
    ext_en[8] <= 1'b1;
    ext_val[8] <= r[0];
    wr(10'h021, 8'h14);
    settle();
    chk("serial_rx", 9'({r[0], 1'b1}), 9'(serial_rx));
    test_done();
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    $display("wrong value run_time expected end seen limit");
    test_done();
  end
endmodule // p0pc_port0_pin_config_tb
